// [design/sswcr_top.sv]
// software style control register bank with wishbone slave and parity handling
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
module sswcr_top
  import sswcr_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       soft_reset,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [sswcr_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       mst_req,
  input  wire logic [31:0]                mst_ptr,
  output logic      [31:0]                mst_addr,
  output logic                            mst_addr_valid,
  output logic                            mst_upper_oe,
  input  wire logic                       data_parity_err,
  input  wire logic                       data_parity_as_target,
  input  wire logic                       addr_parity_err,
  output logic                            buffer_parity_error_flag,
  output logic                            parity_err_report,
  output logic                            structure_width_flag,
  output logic                            desc_burst_enable,
  output logic                            io_dword_mode,
  output logic                            irq
);

  import sswcr_pkg::*;

  logic [STYLE_W-1:0]   style_reg;
  logic                 par_en_reg;
  logic                 width_flag_reg;
  logic                 burst_reg;
  logic                 stop_reg;
  logic                 suspend_reg;
  logic                 io_dword_mode_reg;
  logic [INIT_HI_W-1:0] init_hi_reg;
  logic [IRQ_W-1:0]     irq_status_reg;
  logic [IRQ_W-1:0]     irq_mask_reg;
  logic [IRQ_W-1:0]     irq_event;
  logic [31:0]          rd_data_next;
  logic                 req;
  logic                 wr;
  logic                 halted;
  logic                 sel_style;
  logic                 wr_style;
  logic                 wr_refused;
  logic                 width_next;
  logic                 burst_next;
  logic                 style_rsvd;
  logic [STYLE_W-1:0]   style_next;

  // one request per handshake; ack drops the cycle after it was given
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = req && wb_we_i;
  assign halted = stop_reg || suspend_reg;

  // both locations reach the same storage
  assign sel_style = (wb_adr_i == OFF_STYLE) || (wb_adr_i == OFF_STYLE_ALIAS);
  assign wr_style  = wr && sel_style && halted;
  assign wr_refused = wr && sel_style && !halted && (wb_sel_i[0] || wb_sel_i[1]);

  assign style_next = (wr_style && wb_sel_i[0]) ? wb_dat_i[STYLE_W-1:0] : style_reg;

  sswcr_style_decode u_decode
  (
    .software_layout_select (style_next),
    .structure_width_flag   (width_next),
    .desc_burst_enable      (burst_next),
    .style_reserved         (style_rsvd)
  );

  sswcr_addr_gen u_addr
  (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .mst_req                 (mst_req),
    .mst_ptr                 (mst_ptr),
    .width_flag              (structure_width_flag),  // registered output flag, one cycle behind the width flag that software reads
    .init_block_address_high (init_hi_reg),
    .mst_addr                (mst_addr),
    .mst_addr_valid          (mst_addr_valid),
    .mst_upper_oe            (mst_upper_oe)
  );

  // style field: only hardware reset clears it, soft reset leaves it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      style_reg <= STYLE_RESET;
    end
    else if (wr_style && wb_sel_i[0])
    begin
      style_reg <= wb_dat_i[STYLE_W-1:0];
    end
  end

  // derived width flag and burst mode follow the style, never written directly
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      width_flag_reg <= 1'b0;
      burst_reg      <= 1'b0;
    end
    else
    begin
      width_flag_reg <= width_next;
      burst_reg      <= burst_next;
    end
  end

  // parity enable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      par_en_reg <= 1'b0;
    end
    else if (wr_style && wb_sel_i[1])
    begin
      par_en_reg <= wb_dat_i[PAR_EN_BIT];
    end
  end

  // run control: stop, suspend and io width; soft reset forces stop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {io_dword_mode_reg, suspend_reg, stop_reg} <= RUN_CTRL_RESET;
    end
    else if (wr && wb_adr_i == OFF_RUN_CTRL && wb_sel_i[0])
    begin
      stop_reg    <= wb_dat_i[RUN_STOP_BIT] || soft_reset;
      suspend_reg <= wb_dat_i[RUN_SUSPEND_BIT];
      io_dword_mode_reg    <= wb_dat_i[RUN_IO_DWORD_MODE_BIT];
    end
    else if (soft_reset)
    begin
      stop_reg <= 1'b1;
    end
  end

  // upper init block address bits
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      init_hi_reg <= INIT_HI_RESET;
    end
    else if (wr && wb_adr_i == OFF_INIT_ADDR_UP && wb_sel_i[0])
    begin
      init_hi_reg <= wb_dat_i[INIT_HI_W-1:0];
    end
  end

  // interrupt events
  always_comb
  begin
    irq_event                    = '0;
    irq_event[IRQ_DATA_PERR]     = data_parity_err && !data_parity_as_target;
    irq_event[IRQ_WRITE_REFUSED] = wr_refused;
    // parity enable with a 16-bit style cannot carry the descriptor bit
    irq_event[IRQ_RSVD_STYLE]    = wr_style && (style_rsvd ||
                                   (wb_sel_i[1] && wb_dat_i[PAR_EN_BIT] && !width_next));
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_status_reg <= '0;
    end
    else if (wr && wb_adr_i == OFF_IRQ_STATUS && wb_sel_i[0])
    begin
      irq_status_reg <= (irq_status_reg & ~wb_dat_i[IRQ_W-1:0]) | irq_event;
    end
    else
    begin
      irq_status_reg <= irq_status_reg | irq_event;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_mask_reg <= IRQ_MASK_RESET;
    end
    else if (wr && wb_adr_i == OFF_IRQ_MASK && wb_sel_i[0])
    begin
      irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // parity handling toward descriptors and the error reporter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      buffer_parity_error_flag <= 1'b0;
      parity_err_report        <= 1'b0;
    end
    else
    begin
      buffer_parity_error_flag <= par_en_reg && data_parity_err && !data_parity_as_target;
      // reporting is the same whether or not the enable is set
      parity_err_report        <= addr_parity_err || data_parity_err;
    end
  end

  // mode outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      structure_width_flag <= 1'b0;
      desc_burst_enable    <= 1'b0;
      io_dword_mode        <= 1'b0;
    end
    else
    begin
      structure_width_flag <= width_flag_reg;
      desc_burst_enable    <= burst_reg;
      io_dword_mode        <= io_dword_mode_reg;  // io width ignores the style
    end
  end

  // read mux; reserved bits read as zero
  always_comb
  begin
    rd_data_next = 32'h0000_0000;
    if (sel_style)
    begin
      rd_data_next[PAR_EN_BIT]     = par_en_reg;
      rd_data_next[WIDTH_FLAG_BIT] = width_flag_reg;
      if (halted)
      begin
        rd_data_next[STYLE_W-1:0] = style_reg;
      end
    end
    else if (wb_adr_i == OFF_RUN_CTRL)
    begin
      rd_data_next[RUN_STOP_BIT]    = stop_reg;
      rd_data_next[RUN_SUSPEND_BIT] = suspend_reg;
      rd_data_next[RUN_IO_DWORD_MODE_BIT]    = io_dword_mode_reg;
    end
    else if (wb_adr_i == OFF_INIT_ADDR_UP)
    begin
      rd_data_next[INIT_HI_W-1:0] = init_hi_reg;
    end
    else if (wb_adr_i == OFF_IRQ_STATUS)
    begin
      rd_data_next[IRQ_W-1:0] = irq_status_reg;
    end
    else if (wb_adr_i == OFF_IRQ_MASK)
    begin
      rd_data_next[IRQ_W-1:0] = irq_mask_reg;
    end
  end

  // bus answer: one cycle after the request, unmapped addresses ack with zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
      begin
        wb_dat_o <= rd_data_next;
      end
    end
  end

endmodule

// [design/sswcr_pkg.sv]
// package of constants for the software style control register bank
package sswcr_pkg;

  localparam int          ADDR_W            = 8;
  localparam logic [7:0]  OFF_STYLE         = 8'h00;
  localparam logic [7:0]  OFF_STYLE_ALIAS   = 8'h04;
  localparam logic [7:0]  OFF_RUN_CTRL      = 8'h08;
  localparam logic [7:0]  OFF_INIT_ADDR_UP  = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_STATUS    = 8'h10;
  localparam logic [7:0]  OFF_IRQ_MASK      = 8'h14;

  localparam int          STYLE_LSB         = 0;
  localparam int          STYLE_W           = 8;
  localparam int          WIDTH_FLAG_BIT    = 8;
  localparam int          PAR_EN_BIT        = 10;

  localparam int          RUN_STOP_BIT      = 0;
  localparam int          RUN_SUSPEND_BIT   = 1;
  localparam int          RUN_IO_DWORD_MODE_BIT      = 2;
  localparam int          INIT_HI_W         = 8;

  localparam int          IRQ_W             = 3;
  localparam int          IRQ_DATA_PERR     = 0;
  localparam int          IRQ_WRITE_REFUSED = 1;
  localparam int          IRQ_RSVD_STYLE    = 2;

  localparam logic [7:0]  STYLE_RESET       = 8'h00;
  localparam logic [7:0]  STYLE_LEGACY16    = 8'h00;
  localparam logic [7:0]  STYLE_RSVD01      = 8'h01;
  localparam logic [7:0]  STYLE_32_SINGLE   = 8'h02;
  localparam logic [7:0]  STYLE_32_BURST    = 8'h03;
  localparam logic [2:0]  RUN_CTRL_RESET    = 3'h1;
  localparam logic [7:0]  INIT_HI_RESET     = 8'h00;
  localparam logic [2:0]  IRQ_MASK_RESET    = 3'h0;

endpackage

// [design/sswcr_style_decode.sv]
// decode of the software layout select into structure width and burst mode
`timescale 1ns/100ps
module sswcr_style_decode
  import sswcr_pkg::*;
(
  input  wire logic [STYLE_W-1:0] software_layout_select,
  output logic                    structure_width_flag,
  output logic                    desc_burst_enable,
  output logic                    style_reserved
);

  always_comb
  begin
    structure_width_flag = 1'b1;
    desc_burst_enable    = 1'b0;
    style_reserved       = 1'b0;
    unique case (software_layout_select)
      STYLE_LEGACY16:
      begin
        structure_width_flag = 1'b0;
      end
      STYLE_32_SINGLE:
      begin
        desc_burst_enable = 1'b0;
      end
      STYLE_32_BURST:
      begin
        desc_burst_enable = 1'b1;
      end
      default:
      begin
        // 01h and the other unlisted codes read back as 32-bit; they are kept and all marked reserved
        style_reserved = 1'b1;
      end
    endcase
  end

endmodule

// [design/sswcr_addr_gen.sv]
// master address former: merges init upper bits for 16-bit structures
`timescale 1ns/100ps
module sswcr_addr_gen
  import sswcr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 mst_req,
  input  wire logic [31:0]          mst_ptr,
  input  wire logic                 width_flag,
  input  wire logic [INIT_HI_W-1:0] init_block_address_high,
  output logic [31:0]               mst_addr,
  output logic                      mst_addr_valid,
  output logic                      mst_upper_oe
);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mst_addr <= 32'h0000_0000;
    end
    else if (mst_req)
    begin
      if (width_flag)
      begin
        mst_addr <= mst_ptr;
      end
      else
      begin
        mst_addr <= {init_block_address_high, mst_ptr[23:0]};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mst_addr_valid <= 1'b0;
      mst_upper_oe   <= 1'b0;
    end
    else
    begin
      mst_addr_valid <= mst_req;
      mst_upper_oe   <= mst_req;  // independent of width flag
    end
  end

endmodule

// [dv/sswcr_chk.sv]
// assertion checker for the software style control register bank
`timescale 1ns/100ps
module sswcr_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        mst_req,
  input wire logic [31:0] mst_ptr,
  input wire logic [31:0] mst_addr,
  input wire logic        mst_addr_valid,
  input wire logic        mst_upper_oe,
  input wire logic        data_parity_err,
  input wire logic        data_parity_as_target,
  input wire logic        addr_parity_err,
  input wire logic        buffer_parity_error_flag,
  input wire logic        parity_err_report,
  input wire logic        structure_width_flag,
  input wire logic        desc_burst_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack is not a one-cycle answer");
  upper_drive_a: assert property (mst_req |=> mst_addr_valid && mst_upper_oe)
    else $error("upper address not driven after master request");
  addr_low_a: assert property (mst_req && !structure_width_flag |=>
    ((mst_addr ^ $past(mst_ptr)) & 32'h00FF_FFFF) == 32'h0)
    else $error("low address bits differ from pointer");
  addr_full_a: assert property (mst_req && structure_width_flag |=> mst_addr == $past(mst_ptr))
    else $error("full pointer not used as address");
  target_bpe_a: assert property (data_parity_err && data_parity_as_target |=> !buffer_parity_error_flag)
    else $error("buffer parity flag set for target error");
  bpe_cause_a: assert property (buffer_parity_error_flag |-> $past(data_parity_err))
    else $error("buffer parity flag without data parity error");
  err_report_a: assert property (data_parity_err || addr_parity_err |=> parity_err_report)
    else $error("parity error not reported");
  burst_width_a: assert property (desc_burst_enable |-> structure_width_flag)
    else $error("burst style without 32-bit width flag");
  width_write_a: assert property ($changed(structure_width_flag) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("width flag changed without a bus write");
endmodule

bind sswcr_top sswcr_chk i_sswcr_chk (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mst_req(mst_req), .mst_ptr(mst_ptr),
  .mst_addr(mst_addr), .mst_addr_valid(mst_addr_valid), .mst_upper_oe(mst_upper_oe),
  .data_parity_err(data_parity_err), .data_parity_as_target(data_parity_as_target),
  .addr_parity_err(addr_parity_err), .buffer_parity_error_flag(buffer_parity_error_flag),
  .parity_err_report(parity_err_report), .structure_width_flag(structure_width_flag),
  .desc_burst_enable(desc_burst_enable));

// [dv/tb.sv]
// self-checking testbench for the software style control register bank
`timescale 1ns/100ps
module tb;
  import sswcr_pkg::*;
  logic        clk, reset_n, soft_reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, mst_ptr, mst_addr, rd;
  logic        mst_req, mst_addr_valid, mst_upper_oe, irq, io_dword_mode;
  logic        data_parity_err, data_parity_as_target, addr_parity_err;
  logic        buffer_parity_error_flag, parity_err_report, structure_width_flag;
  logic        desc_burst_enable;
  int          error_cnt, samples_checked, cycles;

  sswcr_top i_sswcr_top (.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mst_req(mst_req), .mst_ptr(mst_ptr), .mst_addr(mst_addr),
    .mst_addr_valid(mst_addr_valid), .mst_upper_oe(mst_upper_oe),
    .data_parity_err(data_parity_err), .data_parity_as_target(data_parity_as_target),
    .addr_parity_err(addr_parity_err), .buffer_parity_error_flag(buffer_parity_error_flag),
    .parity_err_report(parity_err_report), .structure_width_flag(structure_width_flag),
    .desc_burst_enable(desc_burst_enable), .io_dword_mode(io_dword_mode), .irq(irq));

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle, released only at the edge that samples ack
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // width flag, burst, dword io, irq
  task automatic outs(input logic [3:0] e);
    check({28'h0, structure_width_flag, desc_burst_enable, io_dword_mode, irq}, {28'h0, e});
  endtask

  task automatic mreq(input logic [31:0] p, input logic [31:0] e);
    @(posedge clk);
    mst_req <= 1'b1;
    mst_ptr <= p;
    @(posedge clk);
    mst_req <= 1'b0;
    #1;
    check(mst_addr, e);
    check({30'h0, mst_addr_valid, mst_upper_oe}, 32'h3);
  endtask

  task automatic perr(input logic dp, input logic tg, input logic ap, input logic [1:0] e);
    @(posedge clk);
    data_parity_err       <= dp;
    data_parity_as_target <= tg;
    addr_parity_err       <= ap;
    @(posedge clk);
    data_parity_err <= 1'b0;
    addr_parity_err <= 1'b0;
    #1;
    check({30'h0, buffer_parity_error_flag, parity_err_report}, {30'h0, e});
  endtask

  task automatic t_reset();
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'h1);
    rdc(8'h14, 32'h0);
    rdc(8'h20, 32'h0);
  endtask

  task automatic t_styles();
    logic [7:0] st [4] = '{8'h00, 8'h01, 8'h02, 8'h03};
    foreach (st[i])
    begin
      // bit 8 written as one must be ignored
      wr(8'h00, {24'h1, st[i]});
      idle(2);
      rdc(8'h00, {23'h0, st[i] != 8'h00, st[i]});
      rdc(8'h04, {23'h0, st[i] != 8'h00, st[i]});
      outs({st[i] != 8'h00, st[i] == 8'h03, 2'b00});
    end
    rdc(8'h10, 32'h4);
  endtask

  task automatic t_addr();
    wr(8'h0C, 32'h0000_00A5);
    wr(8'h00, 32'h0);
    idle(2);
    mreq(32'h1234_5678, 32'hA534_5678);
    wr(8'h00, 32'h3);
    idle(2);
    mreq(32'h1234_5678, 32'h1234_5678);
  endtask

  task automatic t_parity();
    wr(8'h00, 32'h403);
    perr(1'b1, 1'b0, 1'b0, 2'b11);
    perr(1'b1, 1'b1, 1'b0, 2'b01);
    perr(1'b0, 1'b0, 1'b1, 2'b01);
    rdc(8'h00, 32'h503);
    wr(8'h00, 32'h003);
    perr(1'b1, 1'b0, 1'b0, 2'b01);
    outs(4'b1100);
  endtask

  task automatic t_refused();
    wr(8'h10, 32'h7);
    wr(8'h14, 32'h2);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h402);
    idle(2);
    outs(4'b1101);
    rdc(8'h10, 32'h2);
    rdc(8'h00, 32'h100);
    wr(8'h10, 32'h2);
    idle(2);
    outs(4'b1100);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rdc(8'h00, 32'h103);
    rdc(8'h08, 32'h1);
  endtask

  task automatic t_dword();
    wr(8'h08, 32'h5);
    idle(1);
    outs(4'b1110);
    wr(8'h08, 32'h1);
    idle(1);
    outs(4'b1100);
  endtask

  task automatic t_hw_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    idle(2);
    @(posedge clk);
    reset_n <= 1'b1;
    rdc(8'h00, 32'h0);
    outs(4'b0000);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  initial
  begin
    reset_n = 1'b0;
    soft_reset = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    mst_req = 1'b0;
    mst_ptr = 32'h0;
    data_parity_err = 1'b0;
    data_parity_as_target = 1'b0;
    addr_parity_err = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_styles();
    t_addr();
    t_parity();
    t_refused();
    t_dword();
    t_hw_reset();
    complete_run();
  end
endmodule
